// ### bench/port_phy_control_status_regs_assertions.sv
`timescale 1ns/1ps
module port_phy_control_status_regs_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire phy_regs_pkg::phy_state_s port1_phy,
    input wire phy_regs_pkg::forced_mode_s port1_forced,
    input wire phy_regs_pkg::mac_flow_s port1_mac,
    input wire phy_regs_pkg::mac_flow_s port3_mac,
    input wire logic port3_speed_100,
    input wire logic port3_full_duplex,
    input wire logic [3:0] port1_led_in,
    input wire phy_regs_pkg::port_drive_s port1_drive,
    input wire phy_regs_pkg::port_drive_s port2_drive,
    input wire logic port1_algo_sel
);
    // ****************************************************************
    // helper state
    // ****************************************************************
    logic [7:0] p1_ctrl;
    logic [7:0] wdata_q;
    phy_regs_pkg::phy_state_s p1_phy_q;
    phy_regs_pkg::mac_flow_s p1_mac_q;
    phy_regs_pkg::mac_flow_s p3_mac_q;
    phy_regs_pkg::port_drive_s p1_drv_q;
    logic [1:0] p3_link_q;

    // shadow of port 1 control, rebuilt from bus writes only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_ctrl <= 8'h00;
        end else if (wr_en && addr == 8'h1D) begin
            p1_ctrl <= wdata;
        end
    end

    // one-cycle copies so read data can be tied to the request cycle
    always_ff @(posedge clk) begin
        wdata_q <= wdata;
        p1_phy_q <= port1_phy;
        p1_mac_q <= port1_mac;
        p3_mac_q <= port3_mac;
        p1_drv_q <= port1_drive;
        p3_link_q <= {port3_speed_100, port3_full_duplex};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ****************************************************************
    // assertions
    // ****************************************************************
    led_off_a: assert property (port1_drive.led_out == (p1_ctrl[7] ? 4'hF : port1_led_in))
        else $error("port 1 leds do not follow the off bit");
    tx_loop_a: assert property (port1_drive.tx_disable == p1_ctrl[6] && port1_drive.loopback == p1_ctrl[0])
        else $error("port 1 transmit disable or loopback wrong");
    restart_a: assert property ((wr_en && addr == 8'h1D && wdata[5]) |=> port1_drive.restart_an)
        else $error("restart pulse missing after write");
    restart_cause_a: assert property (port1_drive.restart_an |->
        $past(wr_en) && $past(addr) == 8'h1D && wdata_q[5])
        else $error("restart pulse without a write");
    far_end_a: assert property (port1_drive.far_end_enable == !p1_ctrl[4] && !port2_drive.far_end_enable)
        else $error("far-end enable wrong");
    auto_x_a: assert property (port1_drive.auto_crossover == !p1_ctrl[2] && port1_drive.crossover_mdix ==
        (p1_ctrl[2] ? !p1_ctrl[1] : port1_phy.mdix_auto))
        else $error("crossover drive wrong");
    stat_a_read_a: assert property ((rd_en && addr == 8'h1E) |=>
        rdata == {p1_drv_q.crossover_mdix, p1_phy_q.an_done, p1_phy_q.link_good, p1_phy_q.partner})
        else $error("status a read wrong");
    stat_b_read_a: assert property ((rd_en && addr == 8'h1F) |=> rdata[6:1] == {1'h0, p1_phy_q.polarity_rev,
        p1_mac_q.tx_fc, p1_mac_q.rx_fc, p1_drv_q.speed_100, p1_drv_q.full_duplex})
        else $error("status b read wrong");
    port3_read_a: assert property ((rd_en && addr == 8'h3F) |=>
        rdata[6:0] == {2'h0, p3_mac_q.tx_fc, p3_mac_q.rx_fc, p3_link_q, 1'h0})
        else $error("port 3 status read wrong");
    empty_read_a: assert property ((rd_en && !(addr inside {8'h1D, 8'h1E, 8'h1F, 8'h2D, 8'h2E, 8'h2F, 8'h3F}))
        |=> rdata == 8'h00)
        else $error("reserved slot read not zero");
    algo_write_a: assert property ((wr_en && addr == 8'h1F) |=> port1_algo_sel == wdata_q[7])
        else $error("algorithm select not stored");
    forced_a: assert property (port1_drive.speed_100 == (port1_forced.an_enable ? port1_phy.an_speed_100 :
        port1_forced.force_speed_100) && port1_drive.full_duplex == ((port1_forced.an_enable &&
        port1_phy.an_done) ? port1_phy.an_full_duplex : port1_forced.force_full_duplex))
        else $error("speed or duplex selection wrong");

    // main scenarios reached
    cover property (wr_en && addr == 8'h1D && wdata[5]);
    cover property (rd_en && addr == 8'h3D);
    cover property (port1_drive.led_out == 4'hF && port1_drive.loopback);
endmodule : port_phy_control_status_regs_assertions

// ### bench/port_phy_control_status_regs_tb_top.sv
`timescale 1ns/1ps
module port_phy_control_status_regs_tb_top;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'h0;
    logic rd_en = 1'h0;
    logic [7:0] rdata;
    logic x_off_strap = 1'h1;
    logic straight_strap = 1'h1;
    phy_regs_pkg::phy_state_s p1_phy = '{1'h1, 1'h1, 1'h0, 5'h15, 1'h1, 1'h1, 1'h1, 1'h0};
    phy_regs_pkg::phy_state_s p2_phy = '{1'h0, 1'h0, 1'h1, 5'h0A, 1'h0, 1'h1, 1'h0, 1'h1};
    phy_regs_pkg::forced_mode_s p1_forced = '{1'h1, 1'h0, 1'h1};
    phy_regs_pkg::forced_mode_s p2_forced = '{1'h0, 1'h1, 1'h0};
    phy_regs_pkg::mac_flow_s p1_mac = '{1'h1, 1'h0};
    phy_regs_pkg::mac_flow_s p2_mac = '{1'h0, 1'h1};
    phy_regs_pkg::mac_flow_s p3_mac = '{1'h1, 1'h1};
    logic p3_speed = 1'h0;
    logic p3_duplex = 1'h1;
    logic [3:0] p1_led = 4'h6;
    logic [3:0] p2_led = 4'h9;
    phy_regs_pkg::port_drive_s p1_drive;
    phy_regs_pkg::port_drive_s p2_drive;
    logic p1_algo;
    logic p2_algo;
    int failures = 0;
    int total_checks = 0;
    // address, write data, expected read back
    // status b writes keep the reserved bit 6 at zero
    logic [23:0] rows [12] = '{24'h1DA5A5, 24'h1E00D5, 24'h1F3F35, 24'h2D5A5A, 24'h2E002A, 24'h2F808C,
        24'h3F001A, 24'h3DFF00, 24'h3EFF00, 24'h00FF00, 24'h1D1010, 24'h1F80B4};

    port_phy_control_status_regs u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .port2_auto_crossover_off_strap(x_off_strap),
        .port2_force_straight_strap(straight_strap), .port1_phy(p1_phy), .port2_phy(p2_phy),
        .port1_forced(p1_forced), .port2_forced(p2_forced), .port1_mac(p1_mac), .port2_mac(p2_mac),
        .port3_mac(p3_mac), .port3_speed_100(p3_speed), .port3_full_duplex(p3_duplex),
        .port1_led_in(p1_led), .port2_led_in(p2_led), .port1_drive(p1_drive), .port2_drive(p2_drive),
        .port1_algo_sel(p1_algo), .port2_algo_sel(p2_algo));

    // 25 MHz clock
    always #20 clk = ~clk;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    // hold reset eight cycles, then leave the strap cycle alone
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'h0;
        repeat (8) @(posedge clk);
        resetn <= 1'h1;
        repeat (2) @(posedge clk);
    endtask : do_reset

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        do_reset();
        for (int i = 0; i < 12; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd_chk(rows[i][23:16], rows[i][7:0]);
        end
        wr(8'h1D, 8'hC1);
        chk({4'h0, p1_drive.led_out}, 8'h0F);
        chk({7'h00, p1_drive.tx_disable}, 8'h01);
        chk({7'h00, p1_drive.loopback}, 8'h01);
        chk({6'h00, p1_drive.far_end_enable, p2_drive.far_end_enable}, 8'h02);
        wr(8'h1D, 8'h20);
        chk({4'h0, p1_drive.led_out}, 8'h06);
        chk({6'h00, p1_drive.tx_disable, p1_drive.restart_an}, 8'h01);
        @(posedge clk);
        p1_forced <= '{1'h0, 1'h0, 1'h1};
        p1_phy.link_good <= 1'h1;
        #1;
        chk({7'h00, p1_drive.restart_an}, 8'h00);
        rd_chk(8'h1F, 8'hB3);
        chk({6'h00, p1_drive.speed_100, p1_drive.full_duplex}, 8'h01);
        rd_chk(8'h1E, 8'hF5);
        rd_chk(8'h1E, 8'hF5);
        do_reset();
        rd_chk(8'h2D, 8'h06);
        chk({6'h00, p2_drive.auto_crossover, p2_drive.crossover_mdix}, 8'h00);
        rd_chk(8'h1D, 8'h00);
        rd_chk(8'h2F, 8'h8C);
        rd_chk(8'h3F, 8'h9A);
        wr(8'h2D, 8'hE9);
        chk({p2_drive.led_out, p2_drive.tx_disable, p2_drive.power_down, 2'h0}, 8'hFC);
        chk({6'h00, p2_drive.restart_an, p2_drive.loopback}, 8'h03);
        wr(8'h2F, 8'h00);
        chk({6'h00, p1_algo, p2_algo}, 8'h02);
        finish_test();
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule : port_phy_control_status_regs_tb_top

bind port_phy_control_status_regs port_phy_control_status_regs_assertions u_chk (.clk(clk), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .port1_phy(port1_phy),
    .port1_forced(port1_forced), .port1_mac(port1_mac), .port3_mac(port3_mac), .port3_speed_100(port3_speed_100),
    .port3_full_duplex(port3_full_duplex), .port1_led_in(port1_led_in), .port1_drive(port1_drive),
    .port2_drive(port2_drive), .port1_algo_sel(port1_algo_sel));

// ### core/phy_port_drive.sv
`timescale 1ns/1ps
module phy_port_drive #(
    parameter bit FIBER = 1'b0
) (
    input wire logic [7:0] ctrl,
    input wire logic restart_pulse,
    input wire logic [3:0] led_in,
    input wire phy_regs_pkg::forced_mode_s forced,
    input wire phy_regs_pkg::phy_state_s phy,
    output phy_regs_pkg::port_drive_s drive
);

    // decode one control byte into the phy's steering signals
    always_comb begin
        drive.led_out = ctrl[phy_regs_pkg::BIT_LED_OFF] ? phy_regs_pkg::LEDS_ALL_HIGH : led_in;
        drive.tx_disable = ctrl[phy_regs_pkg::BIT_TX_DISABLE];
        drive.power_down = ctrl[phy_regs_pkg::BIT_POWER_DOWN];
        drive.restart_an = restart_pulse;
        drive.far_end_enable = FIBER & ~ctrl[phy_regs_pkg::BIT_FAR_END_OFF];
        drive.auto_crossover = ~ctrl[phy_regs_pkg::BIT_AUTO_X_OFF];
        drive.crossover_mdix = drive.auto_crossover ? phy.mdix_auto : ~ctrl[phy_regs_pkg::BIT_FORCE_MDI];
        drive.loopback = ctrl[phy_regs_pkg::BIT_LOOPBACK];
        if (!forced.an_enable) begin
            drive.speed_100 = forced.force_speed_100;
            drive.full_duplex = forced.force_full_duplex;
        end else if (!phy.an_done) begin
            // negotiation failed: speed from the phy's sense, duplex forced
            drive.speed_100 = phy.an_speed_100;
            drive.full_duplex = forced.force_full_duplex;
        end else begin
            drive.speed_100 = phy.an_speed_100;
            drive.full_duplex = phy.an_full_duplex;
        end
    end

endmodule : phy_port_drive

// ### core/phy_regs_pkg.sv
package phy_regs_pkg;

    // ****************************************************************
    // register offsets, byte wide, at their printed addresses
    // ****************************************************************
    localparam logic [7:0] OFS_P1_CTRL = 8'h1D;
    localparam logic [7:0] OFS_P1_STAT_A = 8'h1E;
    localparam logic [7:0] OFS_P1_STAT_B = 8'h1F;
    localparam logic [7:0] OFS_P2_CTRL = 8'h2D;
    localparam logic [7:0] OFS_P2_STAT_A = 8'h2E;
    localparam logic [7:0] OFS_P2_STAT_B = 8'h2F;
    localparam logic [7:0] OFS_P3_CTRL_RSVD = 8'h3D;
    localparam logic [7:0] OFS_P3_STAT_A_RSVD = 8'h3E;
    localparam logic [7:0] OFS_P3_STAT_B = 8'h3F;

    // ****************************************************************
    // phy control field positions
    // ****************************************************************
    localparam int BIT_LED_OFF = 7;
    localparam int BIT_TX_DISABLE = 6;
    localparam int BIT_RESTART_AN = 5;
    localparam int BIT_FAR_END_OFF = 4;
    localparam int BIT_POWER_DOWN = 3;
    localparam int BIT_AUTO_X_OFF = 2;
    localparam int BIT_FORCE_MDI = 1;
    localparam int BIT_LOOPBACK = 0;

    // ****************************************************************
    // link status b field positions
    // ****************************************************************
    localparam int BIT_ALGO_SEL = 7;
    localparam int BIT_STAT_RSVD = 6;
    localparam int BIT_POL_REV = 5;
    localparam int BIT_TX_FC = 4;
    localparam int BIT_RX_FC = 3;
    localparam int BIT_SPEED = 2;
    localparam int BIT_DUPLEX = 1;
    localparam int BIT_FAR_END = 0;

    // ****************************************************************
    // reset values, read-zero byte and led-off level
    // ****************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic ALGO_SEL_RST = 1'b1;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [3:0] LEDS_ALL_HIGH = 4'hF;

    // live phy state of one copper/fiber port
    typedef struct packed {
        logic mdix_auto;
        logic an_done;
        logic link_good;
        logic [4:0] partner;
        logic polarity_rev;
        logic far_end_fault;
        logic an_speed_100;
        logic an_full_duplex;
    } phy_state_s;

    // mac flow-control activity
    typedef struct packed {
        logic tx_fc;
        logic rx_fc;
    } mac_flow_s;

    // forced-mode bits of the companion control register
    typedef struct packed {
        logic an_enable;
        logic force_speed_100;
        logic force_full_duplex;
    } forced_mode_s;

    // everything a port's phy takes from this block except its algorithm select
    typedef struct packed {
        logic [3:0] led_out;
        logic tx_disable;
        logic power_down;
        logic restart_an;
        logic far_end_enable;
        logic auto_crossover;
        logic crossover_mdix;
        logic loopback;
        logic speed_100;
        logic full_duplex;
    } port_drive_s;

    // start-up sequence: one-hot
    typedef enum logic [1:0] {
        STRAP_LOAD = 2'b01,
        RUNNING = 2'b10
    } boot_e;

endpackage : phy_regs_pkg

// ### core/port_phy_control_status_regs.sv
// Operation
// - control bit 7 drives all four port leds high; clear restores them
// - control bit 6 disables the port transmitter
// - writing one to control bit 5 restarts auto-negotiation
// - control bit 4 turns far-end fault off; port 1 only
// - control bit 2 disables auto crossover; port 2 default from strap
// - control bit 1 forces mdi when one, mdi-x when zero; port 2 strap default
// - control bit 0 selects loopback through this port's phy
// - status a bits 7..5: crossover state, negotiation done, link good
// - status a bits 4..0: partner pause, 100 fd, 100 hd, 10 fd, 10 hd
// - status b bit 7 selects crossover algorithm, resets to one
// - status b bit 5 reports reversed receive polarity
// - status b bits 4 and 3 report transmit and receive flow control
// - status b bit 2 reports 100 versus 10 speed
// - status b bit 1 reports full versus half duplex
// - status b bit 0 reports far-end fault, port 1 only
// - layout repeats: port 1 at 1D-1F, port 2 at 2D-2F
// - port 3 has only status b; its other slots read zero
// - with negotiation off, speed and duplex come from forced bits
`timescale 1ns/1ps
module port_phy_control_status_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic port2_auto_crossover_off_strap,
    input wire logic port2_force_straight_strap,
    input wire phy_regs_pkg::phy_state_s port1_phy,
    input wire phy_regs_pkg::phy_state_s port2_phy,
    input wire phy_regs_pkg::forced_mode_s port1_forced,
    input wire phy_regs_pkg::forced_mode_s port2_forced,
    input wire phy_regs_pkg::mac_flow_s port1_mac,
    input wire phy_regs_pkg::mac_flow_s port2_mac,
    input wire phy_regs_pkg::mac_flow_s port3_mac,
    input wire logic port3_speed_100,
    input wire logic port3_full_duplex,
    input wire logic [3:0] port1_led_in,
    input wire logic [3:0] port2_led_in,
    output phy_regs_pkg::port_drive_s port1_drive,
    output phy_regs_pkg::port_drive_s port2_drive,
    output logic port1_algo_sel,
    output logic port2_algo_sel
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // one write strobe aimed at one offset
    function automatic logic write_hit(
        input logic strobe,
        input logic [7:0] a,
        input logic [7:0] ofs
    );
        write_hit = strobe && (a == ofs);
    endfunction : write_hit

    // status a: resolved crossover, negotiation, link and partner flags
    // the crossover bit arrives resolved: live phy sense or forced control bit
    function automatic logic [7:0] status_a_byte(
        input phy_regs_pkg::phy_state_s phy,
        input logic mdix
    );
        status_a_byte = {mdix, phy.an_done, phy.link_good, phy.partner};
    endfunction : status_a_byte

    // status b: one algorithm select bit over live link state
    function automatic logic [7:0] status_b_byte(
        input logic algo,
        input logic pol_rev,
        input phy_regs_pkg::mac_flow_s mac,
        input logic speed,
        input logic duplex,
        input logic fault
    );
        logic [7:0] b;
        b = phy_regs_pkg::READ_ZERO;
        b[phy_regs_pkg::BIT_ALGO_SEL] = algo;
        // reserved bit stays zero whatever software wrote
        b[phy_regs_pkg::BIT_STAT_RSVD] = 1'b0;
        b[phy_regs_pkg::BIT_POL_REV] = pol_rev;
        b[phy_regs_pkg::BIT_TX_FC] = mac.tx_fc;
        b[phy_regs_pkg::BIT_RX_FC] = mac.rx_fc;
        b[phy_regs_pkg::BIT_SPEED] = speed;
        b[phy_regs_pkg::BIT_DUPLEX] = duplex;
        b[phy_regs_pkg::BIT_FAR_END] = fault;
        status_b_byte = b;
    endfunction : status_b_byte

    // ****************************************************************
    // storage
    // ****************************************************************

    logic [7:0] port1_ctrl;
    logic [7:0] port2_ctrl;
    logic port3_algo_sel;
    logic port1_restart;
    logic port2_restart;
    logic [7:0] next_rdata;
    logic port1_fault_seen;
    phy_regs_pkg::boot_e boot_state;

    // decoded write strobes
    logic wr_p1_ctrl;
    logic wr_p2_ctrl;
    logic wr_p1_stat_b;
    logic wr_p2_stat_b;
    logic wr_p3_stat_b;
    logic wr_p2_ctrl_live;

    assign wr_p1_ctrl = write_hit(wr_en, addr, phy_regs_pkg::OFS_P1_CTRL);
    assign wr_p2_ctrl = write_hit(wr_en, addr, phy_regs_pkg::OFS_P2_CTRL);
    assign wr_p1_stat_b = write_hit(wr_en, addr, phy_regs_pkg::OFS_P1_STAT_B);
    assign wr_p2_stat_b = write_hit(wr_en, addr, phy_regs_pkg::OFS_P2_STAT_B);
    assign wr_p3_stat_b = write_hit(wr_en, addr, phy_regs_pkg::OFS_P3_STAT_B);

    // a port 2 write lost to the strap cycle must not restart negotiation either
    assign wr_p2_ctrl_live = wr_p2_ctrl && (boot_state != phy_regs_pkg::STRAP_LOAD);

    // ****************************************************************
    // start-up: catch the port 2 straps once after reset release
    // ****************************************************************

    // straps are read by a clock edge after release, never by the reset
    // a port 2 control write landing in that first cycle is lost to the straps
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_state <= phy_regs_pkg::STRAP_LOAD;
        end else begin
            case (boot_state)
                phy_regs_pkg::STRAP_LOAD: begin
                    boot_state <= phy_regs_pkg::RUNNING;
                end
                phy_regs_pkg::RUNNING: begin
                    boot_state <= phy_regs_pkg::RUNNING;
                end
                default: begin
                    boot_state <= phy_regs_pkg::STRAP_LOAD;
                end
            endcase
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************

    // port 1 control; no straps, plain reset value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port1_ctrl <= phy_regs_pkg::CTRL_RST;
        end else if (wr_p1_ctrl) begin
            port1_ctrl <= wdata;
        end
    end

    // port 2 control; crossover bits take the straps in the load cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port2_ctrl <= phy_regs_pkg::CTRL_RST;
        end else if (boot_state == phy_regs_pkg::STRAP_LOAD) begin
            port2_ctrl[phy_regs_pkg::BIT_AUTO_X_OFF] <= port2_auto_crossover_off_strap;
            port2_ctrl[phy_regs_pkg::BIT_FORCE_MDI] <= port2_force_straight_strap;
        end else if (wr_p2_ctrl) begin
            port2_ctrl <= wdata;
        end
    end

    // restart pulse on write
    // a write of one fires one pulse even if the bit already held one
    // the stored bit 5 only reads back; this pulse alone drives the phy
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port1_restart <= 1'b0;
            port2_restart <= 1'b0;
        end else begin
            port1_restart <= wr_p1_ctrl && wdata[phy_regs_pkg::BIT_RESTART_AN];
            port2_restart <= wr_p2_ctrl_live && wdata[phy_regs_pkg::BIT_RESTART_AN];
        end
    end

    // ****************************************************************
    // status b writable bit
    // ****************************************************************

    // only bit 7 is stored, so a write to bit 6 has no effect
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port1_algo_sel <= phy_regs_pkg::ALGO_SEL_RST;
            port2_algo_sel <= phy_regs_pkg::ALGO_SEL_RST;
            port3_algo_sel <= phy_regs_pkg::ALGO_SEL_RST;
        end else begin
            if (wr_p1_stat_b) begin
                port1_algo_sel <= wdata[phy_regs_pkg::BIT_ALGO_SEL];
            end
            if (wr_p2_stat_b) begin
                port2_algo_sel <= wdata[phy_regs_pkg::BIT_ALGO_SEL];
            end
            // kept for read-back only; port 3 has no phy to steer
            if (wr_p3_stat_b) begin
                port3_algo_sel <= wdata[phy_regs_pkg::BIT_ALGO_SEL];
            end
        end
    end

    // ****************************************************************
    // per-port phy steering
    // ****************************************************************

    // both ports share one decoder; only the fiber parameter differs
    // port 1 is the fiber-capable port
    phy_port_drive #(
        .FIBER(1'b1)
    ) u_port1_drive (
        .ctrl(port1_ctrl),
        .restart_pulse(port1_restart),
        .led_in(port1_led_in),
        .forced(port1_forced),
        .phy(port1_phy),
        .drive(port1_drive)
    );

    // port 2 is copper only
    phy_port_drive #(
        .FIBER(1'b0)
    ) u_port2_drive (
        .ctrl(port2_ctrl),
        .restart_pulse(port2_restart),
        .led_in(port2_led_in),
        .forced(port2_forced),
        .phy(port2_phy),
        .drive(port2_drive)
    );

    // fault flag gated by fiber enable
    // with detection disabled the phy's flag is not trusted
    assign port1_fault_seen = port1_drive.far_end_enable & port1_phy.far_end_fault;

    // ****************************************************************
    // read path
    // ****************************************************************

    // live status sampled at the read
    always_comb begin
        next_rdata = phy_regs_pkg::READ_ZERO;
        case (addr)
            // port 1 slots
            phy_regs_pkg::OFS_P1_CTRL: begin
                next_rdata = port1_ctrl;
            end

            phy_regs_pkg::OFS_P1_STAT_A: begin
                next_rdata = status_a_byte(
                    port1_phy,
                    port1_drive.crossover_mdix
                );
            end

            phy_regs_pkg::OFS_P1_STAT_B: begin
                next_rdata = status_b_byte(
                    port1_algo_sel,
                    port1_phy.polarity_rev,
                    port1_mac,
                    port1_drive.speed_100,
                    port1_drive.full_duplex,
                    port1_fault_seen
                );
            end

            // port 2 slots
            phy_regs_pkg::OFS_P2_CTRL: begin
                next_rdata = port2_ctrl;
            end

            phy_regs_pkg::OFS_P2_STAT_A: begin
                next_rdata = status_a_byte(
                    port2_phy,
                    port2_drive.crossover_mdix
                );
            end

            phy_regs_pkg::OFS_P2_STAT_B: begin
                // copper port never reports far-end fault
                next_rdata = status_b_byte(
                    port2_algo_sel,
                    port2_phy.polarity_rev,
                    port2_mac,
                    port2_drive.speed_100,
                    port2_drive.full_duplex,
                    1'b0
                );
            end

            // port 3 slots
            phy_regs_pkg::OFS_P3_STAT_B: begin
                // mii port: no polarity, no fault
                next_rdata = status_b_byte(
                    port3_algo_sel,
                    1'b0,
                    port3_mac,
                    port3_speed_100,
                    port3_full_duplex,
                    1'b0
                );
            end

            phy_regs_pkg::OFS_P3_CTRL_RSVD, phy_regs_pkg::OFS_P3_STAT_A_RSVD: begin
                next_rdata = phy_regs_pkg::READ_ZERO;
            end

            default: begin
                next_rdata = phy_regs_pkg::READ_ZERO;
            end
        endcase
    end

    // read data stands one cycle after the strobe only, zero otherwise
    // zeroing between reads keeps a stale byte from passing for a fresh answer
    // cost: software must take the byte in the single cycle after its strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= phy_regs_pkg::READ_ZERO;
        end else if (rd_en) begin
            rdata <= next_rdata;
        end else begin
            rdata <= phy_regs_pkg::READ_ZERO;
        end
    end

endmodule : port_phy_control_status_regs
